// [hdl/fct_timer.sv]
// Four-channel capture/compare timer with 16-bit counter and prescaler.
// Assumes a single-cycle 8-bit register port and pins synchronous to the clock.
//
// Operation
// - The 16-bit up-counter runs free or wraps at the modulo limit, as chosen by software.
// - The modulo limit is one 16-bit value built from its high and low byte registers.
// - Reading the counter never stops, pauses or changes the count.
// - Each of the four channels is set up on its own for capture or compare.
// - The count clock is one of seven bus clock divisions or the external clock pin.
// - A three-bit prescale select field in the main control register picks that clock.
// - A capture channel triggers on rising, falling or either edge of its pin.
// - A compare channel sets, clears or toggles its pin on a match.
// - Each compare channel may toggle its pin whenever the counter overflows.
// - One control bit halts the counter and another resets counter and prescaler.
// - Pulse-width outputs come either direct or double-buffered across a channel pair.
// - An active capture edge copies the count into the channel value registers.
// - When the count equals a compare channel's value, that channel's pin action runs.
`timescale 1ns/1ps
module fct_timer
  import fct_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_b_in,
  // Register port
  input  wire fct_bus_s          bus_in,
  output logic [7:0]             rdata_out,
  // External count clock
  input  wire logic              ext_timer_clock_pin_in,
  // Channel pins, bit 0 is channel_pin_zero
  input  wire logic [NUM_CH-1:0] channel_pin_in,
  output logic [NUM_CH-1:0]      channel_pin_out,
  output logic [NUM_CH-1:0]      channel_pin_oe_out,
  // Interrupt
  output logic                   irq_out
);

  localparam int NP = NUM_CH / 2;

  logic              stop_q;
  logic              moden_q;
  logic [2:0]        ps_q;
  logic [15:0]       mod_q;
  logic [15:0]       cnt_q;
  logic [5:0]        pre_q;
  logic              ext_prev_q;
  logic              upd_q;
  logic              wrap_q;
  logic              lo_lat_q;
  logic [7:0]        lo_buf_q;
  logic [NUM_CH:0]   irq_st_q;
  logic [NUM_CH:0]   irq_mk_q;
  logic [7:0]        rdata_q;
  fct_chcfg_s        chcfg_q [NUM_CH];
  logic [15:0]       act_q [NP];
  logic [NP-1:0]     lastw_q;

  logic              wr_sc;
  logic              rst_wr;
  logic              rd_cnt_h;
  logic              rd_cnt_l;
  logic              rd_ist;
  logic [5:0]        ps_mask;
  logic              int_tick;
  logic              ext_rise;
  logic              tick;
  logic              at_top;
  logic              ovf_ev;
  logic [7:0]        rd_mux;
  logic [NUM_CH-1:0] ch_sel_sc;
  logic [NUM_CH-1:0] ch_sel_hi;
  logic [NUM_CH-1:0] ch_sel_lo;
  logic [NUM_CH-1:0] ch_ev;
  logic [NUM_CH-1:0] ch_oe;
  logic [NUM_CH-1:0] slave;
  logic [15:0]       ch_val [NUM_CH];
  logic [NUM_CH:0]   irq_st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Main register decode
  assign wr_sc    = bus_in.wr && bus_in.addr == OFS_SC;
  assign rst_wr   = wr_sc && bus_in.wdata[SC_RST];
  assign rd_cnt_h = bus_in.rd && bus_in.addr == OFS_CNT_H;
  assign rd_cnt_l = bus_in.rd && bus_in.addr == OFS_CNT_L;
  assign rd_ist   = bus_in.rd && bus_in.addr == OFS_IRQ_ST;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: rate is bus clock over 2 to the power of the select
  assign ps_mask  = 6'((7'h01 << ps_q) - 7'h01);
  assign int_tick = (pre_q & ps_mask) == ps_mask;
  // External clock sampled here, so its period must span several cycles
  assign ext_rise = ext_timer_clock_pin_in && !ext_prev_q;
  assign tick     = !stop_q && (ps_q == PS_EXT ? ext_rise : int_tick);

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      pre_q      <= 6'h00;
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_timer_clock_pin_in;
      if (rst_wr) begin
        pre_q <= 6'h00;
      end else if (!stop_q) begin
        pre_q <= pre_q + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter; a limit of all ones makes modulo mode behave as free running
  assign at_top = moden_q ? cnt_q == mod_q : cnt_q == CNT_TOP;
  assign ovf_ev = tick && at_top && !rst_wr;

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      cnt_q  <= 16'h0000;
      upd_q  <= 1'b0;
      wrap_q <= 1'b0;
    end else begin
      upd_q  <= tick && !rst_wr;
      wrap_q <= ovf_ev;
      if (rst_wr) begin
        cnt_q <= 16'h0000;
      end else if (tick) begin
        cnt_q <= at_top ? 16'h0000 : cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; counter read latches the low byte for a coherent pair
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      stop_q   <= SC_RESET[SC_STOP];
      moden_q  <= SC_RESET[SC_MODEN];
      ps_q     <= SC_RESET[2:0];
      mod_q    <= MOD_RESET;
      lo_lat_q <= 1'b0;
      lo_buf_q <= 8'h00;
      irq_mk_q <= '0;
    end else begin
      if (wr_sc) begin
        stop_q  <= bus_in.wdata[SC_STOP];
        moden_q <= bus_in.wdata[SC_MODEN];
        ps_q    <= bus_in.wdata[2:0];
      end
      if (bus_in.wr && bus_in.addr == OFS_MOD_H) begin
        mod_q[15:8] <= bus_in.wdata;
      end
      if (bus_in.wr && bus_in.addr == OFS_MOD_L) begin
        mod_q[7:0] <= bus_in.wdata;
      end
      if (bus_in.wr && bus_in.addr == OFS_IRQ_MK) begin
        irq_mk_q <= bus_in.wdata[NUM_CH:0];
      end
      // Reads only copy the count, they never touch the counter
      if (rd_cnt_h) begin
        lo_buf_q <= cnt_q[7:0];
        lo_lat_q <= 1'b1;
      end else if (rd_cnt_l) begin
        lo_lat_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels, their decode and configuration
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic [4:0] A = OFS_CH0 + 5'(CH_STRIDE * i);
    fct_chcfg_s  cfg;
    logic [15:0] cmp;

    assign ch_sel_sc[i] = bus_in.addr == A;
    assign ch_sel_hi[i] = bus_in.addr == A + 5'h01;
    assign ch_sel_lo[i] = bus_in.addr == A + 5'h02;
    // Odd half of a buffered pair is silent and only holds the next value
    assign slave[i] = (i % 2 == 1) && chcfg_q[i - (i % 2)].buf_en;
    assign cfg      = slave[i] ? '0 : chcfg_q[i];
    assign cmp      = (i % 2 == 0 && chcfg_q[i].buf_en) ? act_q[i / 2] : ch_val[i];
    assign channel_pin_oe_out[i] = ch_oe[i];

    always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
        chcfg_q[i] <= '0;
      end else if (bus_in.wr && ch_sel_sc[i]) begin
        chcfg_q[i].buf_en <= (i % 2 == 0) && bus_in.wdata[CH_BUF];
        chcfg_q[i].cmp_en <= bus_in.wdata[CH_CMP];
        chcfg_q[i].els    <= bus_in.wdata[CH_ELS+1:CH_ELS];
        chcfg_q[i].tov    <= bus_in.wdata[CH_TOV];
      end
    end

    fct_chan u_chan (
      .core_clk_in (core_clk_in),
      .rst_b_in    (rst_b_in),
      .cfg_in      (cfg),
      .cnt_in      (cnt_q),
      .upd_in      (upd_q),
      .wrap_in     (wrap_q),
      .cmp_val_in  (cmp),
      .wr_hi_in    (bus_in.wr && ch_sel_hi[i]),
      .wr_lo_in    (bus_in.wr && ch_sel_lo[i]),
      .wdata_in    (bus_in.wdata),
      .pin_in      (channel_pin_in[i]),
      .val_out     (ch_val[i]),
      .pin_out     (channel_pin_out[i]),
      .pin_oe_out  (ch_oe[i]),
      .event_out   (ch_ev[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffered pairs: the last written half loads at overflow, so a duty change
  // never lands mid-period and cannot cause a runt pulse
  for (genvar p = 0; p < NP; p++) begin : g_pair
    logic wr_even;
    logic wr_odd;
    assign wr_even = bus_in.wr && (ch_sel_hi[2*p] || ch_sel_lo[2*p]);
    assign wr_odd  = bus_in.wr && (ch_sel_hi[2*p+1] || ch_sel_lo[2*p+1]);

    always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
        act_q[p]   <= 16'h0000;
        lastw_q[p] <= 1'b0;
      end else begin
        if (wr_odd) begin
          lastw_q[p] <= 1'b1;
        end else if (wr_even) begin
          lastw_q[p] <= 1'b0;
        end
        if (!chcfg_q[2*p].buf_en || wrap_q) begin
          act_q[p] <= lastw_q[p] ? ch_val[2*p+1] : ch_val[2*p];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status: bit 0 overflow, bit i+1 channel i; a new event beats a read
  assign irq_st_d = (rd_ist ? '0 : irq_st_q) | {ch_ev, ovf_ev};
  assign irq_out  = |(irq_st_q & irq_mk_q);

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= irq_st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    rd_mux = 8'h00;
    case (bus_in.addr)
      OFS_SC:     rd_mux = {irq_st_q[0], 1'b0, stop_q, 1'b0, moden_q, ps_q};
      OFS_CNT_H:  rd_mux = cnt_q[15:8];
      OFS_CNT_L:  rd_mux = lo_lat_q ? lo_buf_q : cnt_q[7:0];
      OFS_MOD_H:  rd_mux = mod_q[15:8];
      OFS_MOD_L:  rd_mux = mod_q[7:0];
      OFS_IRQ_ST: rd_mux = 8'(irq_st_q);
      OFS_IRQ_MK: rd_mux = 8'(irq_mk_q);
      default:    rd_mux = 8'h00;
    endcase
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch_sel_sc[i]) begin
        rd_mux = {irq_st_q[i+1], 1'b0, chcfg_q[i].buf_en, chcfg_q[i].cmp_en,
                  chcfg_q[i].els, chcfg_q[i].tov, 1'b0};
      end
      if (ch_sel_hi[i]) begin
        rd_mux = ch_val[i][15:8];
      end
      if (ch_sel_lo[i]) begin
        rd_mux = ch_val[i][7:0];
      end
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= bus_in.rd ? rd_mux : 8'h00;
    end
  end
  assign rdata_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_wrap;
    ovf_ev |=> cnt_q == 16'h0000 && irq_st_q[0];
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap or flag at limit");

  property p_free;
    !moden_q && tick && cnt_q == mod_q && cnt_q != CNT_TOP && !rst_wr
      |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_free: assert property (p_free) else $error("free run stopped at limit");

  property p_mod_wr;
    bus_in.wr && bus_in.addr == OFS_MOD_H |=> mod_q[15:8] == $past(bus_in.wdata);
  endproperty
  a_mod_wr: assert property (p_mod_wr) else $error("limit high byte lost");

  property p_read_cnt;
    (rd_cnt_h || rd_cnt_l) && tick && !at_top |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_read_cnt: assert property (p_read_cnt) else $error("read disturbed count");

  property p_stop;
    stop_q && !rst_wr |=> cnt_q == $past(cnt_q);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while halted");

  property p_rst;
    rst_wr |=> cnt_q == 16'h0000 && pre_q == 6'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset bit ignored");

  property p_ps0;
    !stop_q && ps_q == 3'h0 |-> tick;
  endproperty
  a_ps0: assert property (p_ps0) else $error("undivided rate missed");

  property p_ps2;
    ps_q == 3'h2 && tick |=> (!tick || ps_q != 3'h2) [*3];
  endproperty
  a_ps2: assert property (p_ps2) else $error("divide by four too fast");

  property p_ext;
    ps_q == PS_EXT && tick |-> ext_timer_clock_pin_in && !ext_prev_q;
  endproperty
  a_ext: assert property (p_ext) else $error("external tick without edge");

  property p_rd_clr;
    rd_ist && !ovf_ev && ch_ev == '0 |=> irq_st_q == '0;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("status read did not clear");

endmodule : fct_timer

// [hdl/fct_pkg.sv]
// Shared constants and carriers for the four-channel capture/compare timer.
// Assumes an 8-bit register port with byte offsets relative to the block base.
package fct_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [4:0] OFS_SC     = 5'h00;
  localparam logic [4:0] OFS_CNT_H  = 5'h02;
  localparam logic [4:0] OFS_CNT_L  = 5'h03;
  localparam logic [4:0] OFS_MOD_H  = 5'h04;
  localparam logic [4:0] OFS_MOD_L  = 5'h05;
  localparam logic [4:0] OFS_CH0    = 5'h06;
  localparam int         CH_STRIDE  = 3;
  localparam logic [4:0] OFS_IRQ_ST = 5'h12;
  localparam logic [4:0] OFS_IRQ_MK = 5'h13;

  ////////////////////////////////////////////////////////////////////////////
  // Main control fields and reset values
  localparam int          SC_OVF     = 7;
  localparam int          SC_STOP    = 5;
  localparam int          SC_RST     = 4;
  localparam int          SC_MODEN   = 3;
  localparam logic [7:0]  SC_RESET   = 8'h20;
  localparam logic [15:0] MOD_RESET  = 16'hFFFF;
  localparam logic [15:0] CNT_TOP    = 16'hFFFF;
  localparam logic [2:0]  PS_EXT     = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Channel control fields and edge/level codes
  localparam int         CH_FLAG  = 7;
  localparam int         CH_BUF   = 5;
  localparam int         CH_CMP   = 4;
  localparam int         CH_ELS   = 2;
  localparam int         CH_TOV   = 1;
  localparam logic [1:0] ELS_OFF  = 2'h0;
  localparam logic [1:0] ELS_TGL  = 2'h1;
  localparam logic [1:0] ELS_CLR  = 2'h2;
  localparam logic [1:0] ELS_SET  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS     = 50;
  localparam int EXT_MIN_PERIOD_NS = 250;
  localparam int EXT_MIN_CYC       = (EXT_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } fct_bus_s;

  typedef struct packed {
    logic       buf_en;
    logic       cmp_en;
    logic [1:0] els;
    logic       tov;
  } fct_chcfg_s;

endpackage : fct_pkg

// [hdl/fct_chan.sv]
// One capture/compare channel: edge capture, compare pin action, overflow toggle.
// Assumes the pin input is synchronous and upd/wrap pulse right after a count.
`timescale 1ns/1ps
module fct_chan
  import fct_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  // Configuration and timebase
  input  wire fct_chcfg_s  cfg_in,
  input  wire logic [15:0] cnt_in,
  input  wire logic        upd_in,
  input  wire logic        wrap_in,
  input  wire logic [15:0] cmp_val_in,
  // Value register writes
  input  wire logic        wr_hi_in,
  input  wire logic        wr_lo_in,
  input  wire logic [7:0]  wdata_in,
  // Pin and results
  input  wire logic        pin_in,
  output logic [15:0]      val_out,
  output logic             pin_out,
  output logic             pin_oe_out,
  output logic             event_out
);

  logic [15:0] val_q;
  logic        pin_q;
  logic        prev_q;
  logic        cmp_mode;
  logic        cap_hit;
  logic        match;
  logic        lvl_ov;
  logic        lvl_d;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and events
  assign cmp_mode = cfg_in.cmp_en | cfg_in.buf_en;
  assign cap_hit  = !cmp_mode && ((cfg_in.els[0] && pin_in && !prev_q) ||
                                  (cfg_in.els[1] && !pin_in && prev_q));
  assign match    = cmp_mode && upd_in && cnt_in == cmp_val_in;
  assign event_out = cap_hit | match;

  // Overflow toggle first, so a compare on the same count has the last word
  assign lvl_ov = (cmp_mode && cfg_in.tov && wrap_in) ? !pin_q : pin_q;
  assign lvl_d  = !match                ? lvl_ov :
                  cfg_in.els == ELS_SET ? 1'b1 :
                  cfg_in.els == ELS_CLR ? 1'b0 :
                  cfg_in.els == ELS_TGL ? !lvl_ov : lvl_ov;

  // Pin is only driven in compare modes with a pin action chosen
  assign pin_oe_out = cmp_mode && cfg_in.els != ELS_OFF;
  assign pin_out    = pin_q;
  assign val_out    = val_q;

  ////////////////////////////////////////////////////////////////////////////
  // Value register, edge history and pin level
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      val_q  <= 16'h0000;
      pin_q  <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      prev_q <= pin_in;
      pin_q  <= lvl_d;
      if (cap_hit) begin
        val_q <= cnt_in;
      end else if (wr_hi_in) begin
        val_q[15:8] <= wdata_in;
      end else if (wr_lo_in) begin
        val_q[7:0] <= wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_cap_latch;
    cap_hit |=> val_q == $past(cnt_in);
  endproperty
  a_cap_latch: assert property (p_cap_latch) else $error("capture missed count");

  property p_rise_only;
    !cmp_mode && cfg_in.els == 2'h1 && !pin_in && prev_q && !wr_hi_in && !wr_lo_in
      |=> $stable(val_q);
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("falling edge captured");

  property p_cmp_set;
    match && cfg_in.els == ELS_SET |=> pin_out;
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("set action failed");

  property p_cmp_clr;
    match && cfg_in.els == ELS_CLR |=> !pin_out;
  endproperty
  a_cmp_clr: assert property (p_cmp_clr) else $error("clear action failed");

  property p_ovf_tgl;
    cmp_mode && cfg_in.tov && wrap_in && !match |=> pin_out != $past(pin_out);
  endproperty
  a_ovf_tgl: assert property (p_ovf_tgl) else $error("overflow toggle failed");

endmodule : fct_chan

// [testbench/fct_pin_model.sv]
// Sources on the channel pins and the external count clock.
// Assumes the bench requests levels and clock bursts.
`timescale 1ns/1ps
module fct_pin_model
  import fct_pkg::*;
(
  // Clock and requests
  input  wire logic       core_clk_in,
  input  wire logic [3:0] lvl_req_in,
  input  wire logic       ext_run_in,
  // Pins and edge count
  output logic [3:0]      channel_pin_out,
  output logic            ext_clk_out,
  output int              ext_edges_out
);
  int ph = 0;
  initial begin
    channel_pin_out = 4'h0;
    ext_clk_out = 1'b0;
    ext_edges_out = 0;
  end
  // Pins follow requests on the next edge
  always @(posedge core_clk_in) channel_pin_out <= lvl_req_in;
  // Each phase lasts EXT_MIN_CYC cycles; stands low between bursts
  always @(posedge core_clk_in) begin
    if (ext_run_in || ext_clk_out) begin
      ph <= (ph == EXT_MIN_CYC - 1) ? 0 : ph + 1;
      if (ph == EXT_MIN_CYC - 1) begin
        ext_clk_out <= ~ext_clk_out;
        if (!ext_clk_out) ext_edges_out <= ext_edges_out + 1;
      end
    end else ph <= 0;
  end
endmodule : fct_pin_model

// [testbench/fct_timer_tb_top.sv]
// Bench for the timer: register port, counter, capture, compare.
// Assumes the pin model drives channel pins and the count clock.
`timescale 1ns/1ps
module fct_timer_tb_top
  import fct_pkg::*;
;
  logic        core_clk, rst_b, irq, ext_clk, ext_run, md, ovf, hit, pe;
  fct_bus_s    bus;
  logic [7:0]  rdata, b;
  logic [3:0]  pin_i, pin_o, pin_oe, lvl;
  logic [15:0] v;
  logic [1:0]  acts [3] = '{ELS_SET, ELS_CLR, ELS_TGL};
  int          ext_n, err_total, total_checks, seed, cyc, lim, n, m, e0, tk, d0, d1, c, a;

  fct_timer i_dut (.core_clk_in(core_clk), .rst_b_in(rst_b), .bus_in(bus), .rdata_out(rdata),
    .ext_timer_clock_pin_in(ext_clk), .channel_pin_in(pin_i), .channel_pin_out(pin_o),
    .channel_pin_oe_out(pin_oe), .irq_out(irq));
  fct_pin_model i_pins (.core_clk_in(core_clk), .lvl_req_in(lvl), .ext_run_in(ext_run),
    .channel_pin_out(pin_i), .ext_clk_out(ext_clk), .ext_edges_out(ext_n));

  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Hang guard, well above the few thousand cycles needed
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_pin(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_pin
  // Gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    bus <= '0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    bus <= '0;
    @(negedge core_clk);
    d = rdata;
    @(posedge core_clk);
  endtask : rd
  // High byte first, so the counter low byte is the latched one
  task automatic rd16(input logic [4:0] a, output logic [15:0] d);
    logic [7:0] h;
    logic [7:0] l;
    rd(a, h);
    rd(a + 5'h01, l);
    d = {h, l};
  endtask : rd16
  // Run n+2 cycles from a cleared counter, then halt and compare
  task automatic run_cnt(input logic [2:0] ps);
    md = (ps != 3'h1);
    lim = 8 + ($unsigned($random(seed)) % 60);
    n = 100 + ($unsigned($random(seed)) % 200);
    wr(OFS_MOD_L, 8'(lim));
    wr(OFS_SC, {4'h3, md, ps});
    rd(OFS_IRQ_ST, b);
    e0 = ext_n;
    wr(OFS_SC, {4'h0, md, ps});
    ext_run <= (ps == PS_EXT);
    repeat (n - 4) @(posedge core_clk);
    rd16(OFS_CNT_H, v);
    ext_run <= 1'b0;
    if (ps == PS_EXT) repeat (2 * EXT_MIN_CYC + 4) @(posedge core_clk);
    wr(OFS_SC, {4'h2, md, ps});
    tk = (ps == PS_EXT) ? ext_n - e0 : (n + 2) >> ps;
    ovf = md && (tk > lim);
    rd16(OFS_CNT_H, v);
    chk_reg("count", 16'(md ? tk % (lim + 1) : tk), v);
    chk_pin("irq", ovf, irq);
    rd(OFS_IRQ_ST, b);
    chk_reg("status", {15'h0, ovf}, {8'h00, b});
    rd(OFS_IRQ_ST, b);
    chk_reg("status clr", 16'h0000, {8'h00, b});
    chk_pin("irq clr", 1'b0, irq);
  endtask : run_cnt
  task automatic end_sim();
    $display("Checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    bus = '0;
    rst_b = 1'b0;
    lvl = 4'h0;
    ext_run = 1'b0;
    seed = 15701;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(OFS_SC, b);
    chk_reg("ctrl rst", {8'h00, SC_RESET}, {8'h00, b});
    rd16(OFS_MOD_H, v);
    chk_reg("limit rst", MOD_RESET, v);
    rd(5'h1F, b);
    chk_reg("unmapped", 16'h0000, {8'h00, b});
    wr(OFS_MOD_H, 8'h00);
    wr(OFS_IRQ_MK, 8'h01);
    for (int p = 0; p < 8; p++) run_cnt(3'(p));
    // Compare actions on channel one
    for (int i = 0; i < 3; i++) begin
      m = 10 + ($unsigned($random(seed)) % 40);
      wr(OFS_CH0 + 5'h05, 8'(m));
      wr(OFS_CH0 + 5'h03, {4'h1, acts[i], 2'h0});
      wr(OFS_SC, 8'h30);
      wr(OFS_SC, 8'h00);
      repeat (m) @(posedge core_clk);
      wr(OFS_SC, 8'h20);
      chk_pin("cmp pin", acts[i] != ELS_CLR, pin_o[1]);
      chk_pin("cmp oe", 1'b1, pin_oe[1]);
    end
    // Capture edges on channel zero; halted count is m+2
    for (int e = 1; e < 4; e++) begin
      wr(OFS_CH0, {4'h0, 2'(e), 2'h0});
      wr(OFS_CH0 + 5'h01, 8'h00);
      wr(OFS_CH0 + 5'h02, 8'h00);
      rd(OFS_IRQ_ST, b);
      for (int k = 0; k < 2; k++) begin
        lvl[0] <= ~lvl[0];
        repeat (4) @(posedge core_clk);
        rd(OFS_IRQ_ST, b);
        hit = (k == 0) ? (e != 2) : (e != 1);
        chk_pin("cap flag", hit, b[1]);
      end
      rd16(OFS_CH0 + 5'h01, v);
      chk_reg("cap value", 16'(m + 2), v);
      chk_pin("cap oe", 1'b0, pin_oe[0]);
    end
    // Buffered pair zero: toggle at wrap, clear at duty; halt in the third
    // period between the two duties, where only the buffered value gives high
    lim = 20 + ($unsigned($random(seed)) % 20);
    d0 = 3 + ($unsigned($random(seed)) % 10);
    d1 = 13 + ($unsigned($random(seed)) % 6);
    n = 2 * (lim + 1) + d0 + ($unsigned($random(seed)) % (d1 - d0));
    wr(OFS_MOD_L, 8'(lim));
    wr(OFS_CH0 + 5'h01, 8'h00);
    wr(OFS_CH0 + 5'h02, 8'(d0));
    wr(OFS_CH0, 8'h2A);
    wr(OFS_CH0 + 5'h05, 8'(d1));
    wr(OFS_SC, 8'h38);
    wr(OFS_SC, 8'h08);
    repeat (n - 2) @(posedge core_clk);
    wr(OFS_SC, 8'h28);
    // Model: active duty is the even value until the first wrap
    c = 0;
    a = d0;
    pe = 1'b0;
    for (int t = 0; t < n; t++) begin
      if (c == lim) begin
        c = 0;
        pe = !pe;
        a = d1;
      end else begin
        c++;
        if (c == a) pe = 1'b0;
      end
    end
    rd16(OFS_CNT_H, v);
    chk_reg("pwm count", 16'(c), v);
    chk_pin("pwm pin", pe, pin_o[0]);
    chk_pin("pwm oe", 1'b1, pin_oe[0]);
    chk_pin("pair oe", 1'b0, pin_oe[1]);
    end_sim();
  end
endmodule : fct_timer_tb_top
